// >>> testbench/bdp_host_model.sv
`timescale 1ns/1ns
`include "bdp_map.vh"
// Host application logic on the far side of the port.
module bdp_host_model (
  // Clock.
  input  wire       core_clk,
  // Pins towards the port.
  output reg        in_clk,
  output reg        out_clk,
  output reg        en,
  output reg        sel,
  output wire [7:0] d_wire,
  output wire [2:0] f_wire,
  input  wire [7:0] dut_d,
  input  wire [2:0] dut_f,
  input  wire       dut_oe,
  input  wire       fmt_oe
);
  reg [7:0] drv_d, last_d;
  reg [2:0] drv_f, last_f;
  // Bus level; a line nobody drives flips every cycle.
  assign d_wire = dut_oe ? dut_d : (!sel ? drv_d : ~last_d);
  assign f_wire = fmt_oe ? dut_f : (!sel ? drv_f : ~last_f);
  // Remembers the last level seen on the floating lines.
  always @(posedge core_clk) begin
    last_d <= d_wire;
    last_f <= f_wire;
  end
  // Pins start idle with both port clocks low.
  initial begin
    {in_clk, out_clk, en, sel} = 4'h0;
    {drv_d, drv_f} = 11'h0;
  end
  // One 400 ns frame on one port clock, low outside frames.
  task frame(input bit o);
    begin
      repeat (4) @(posedge core_clk);
      #2 if (o) out_clk = 1'b1; else in_clk = 1'b1;
      repeat (4) @(posedge core_clk);
      #2 {in_clk, out_clk} = 2'h0;
    end
  endtask
  // One transfer, sampled a frame later, then three idle frames.
  task xfer(input e, input s, input bit o, input [7:0] d,
            input [2:0] f, output [10:0] rd);
    begin
      @(posedge core_clk);
      #2 {en, sel, drv_d, drv_f} = {e, s, d, f};
      frame(o);
      repeat (4) @(posedge core_clk);
      #1 rd = {f_wire, d_wire};
      #1 {en, sel} = 2'h0;
      repeat (3) frame(o);
    end
  endtask
endmodule

// >>> testbench/bdp_port_asserts.sv
`timescale 1ns/1ns
`include "bdp_map.vh"
// Watches the host-side ports of the bulk data port.
module bdp_port_asserts (
  // Clock and reset.
  input wire       core_clk,
  input wire       srst,
  // Host pins.
  input wire       mode_bidir,
  input wire       bulk_transfer_enable,
  input wire       bulk_rw_select,
  input wire       half_rate_clock_out,
  input wire       bulk_data_bus_oe,
  input wire [2:0] bulk_format_bus_out,
  input wire       bulk_format_bus_oe,
  input wire       bulk_in_full_flag,
  input wire       bulk_out_available_flag,
  // Link side.
  input wire       rx_valid,
  input wire       rx_ready,
  input wire       tx_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // The divided clock spends two cycles high, then two low.
  sequence s_hi; half_rate_clock_out ##1 half_rate_clock_out; endsequence
  sequence s_lo; !half_rate_clock_out ##1 !half_rate_clock_out; endsequence
  AST_HALF_RATE: assert property (
    $rose(half_rate_clock_out) |-> s_hi ##1 s_lo ##1 half_rate_clock_out)
    else $error("half rate clock period wrong");
  AST_RESET: assert property (
    $past(srst) |-> !bulk_data_bus_oe && !tx_valid && rx_ready &&
    bulk_format_bus_out == `BDP_FMT_IDLE && !bulk_out_available_flag)
    else $error("reset values wrong");
  AST_OE_PAIR: assert property (
    bulk_data_bus_oe == bulk_format_bus_oe)
    else $error("bus enables differ");
  AST_OE_CAUSE: assert property (
    bulk_data_bus_oe |->
    $past(bulk_transfer_enable & bulk_rw_select & mode_bidir, 3))
    else $error("bus driven without a read");
  AST_TX_CAUSE: assert property (
    $rose(tx_valid) |-> $past(bulk_transfer_enable, 3) &&
    !$past(bulk_rw_select, 3))
    else $error("write taken without enable");
  AST_FULL: assert property (
    bulk_in_full_flag |-> tx_valid)
    else $error("full flag with empty fifo");
  AST_AVAIL: assert property (
    rx_valid && rx_ready |-> ##[1:3] bulk_out_available_flag)
    else $error("available flag missing");
  AST_FMT: assert property (
    bulk_format_bus_oe |-> bulk_format_bus_out inside
    {`BDP_FMT_START, `BDP_FMT_CELL, `BDP_FMT_IDLE})
    else $error("bad format code");
endmodule
bind bdp_port bdp_port_asserts u_asserts (
  .core_clk(core_clk), .srst(srst), .mode_bidir(mode_bidir),
  .bulk_transfer_enable(bulk_transfer_enable),
  .bulk_rw_select(bulk_rw_select),
  .half_rate_clock_out(half_rate_clock_out),
  .bulk_data_bus_oe(bulk_data_bus_oe),
  .bulk_format_bus_out(bulk_format_bus_out),
  .bulk_format_bus_oe(bulk_format_bus_oe),
  .bulk_in_full_flag(bulk_in_full_flag),
  .bulk_out_available_flag(bulk_out_available_flag),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid));

// >>> testbench/bdp_port_tb_top.sv
`timescale 1ns/1ns
`include "bdp_map.vh"
module bdp_port_tb_top;
  reg         core_clk, srst, mode_bidir, rx_valid, tx_ready;
  reg  [7:0]  rx_data;
  reg  [2:0]  rx_format;
  reg  [10:0] rd;
  wire        ic, oc, en, sel, oe, foe, hclk, full, avail, drop;
  wire        rx_ready, tx_valid;
  wire [7:0]  din, dout, obus, tx_data;
  wire [2:0]  fin, fout, ofmt, tx_format;
  integer     err_count, cmp_count, i;
  bdp_port u_dut (.core_clk(core_clk), .srst(srst),
    .mode_bidir(mode_bidir), .bulk_in_port_clock(ic),
    .bulk_out_port_clock(oc), .half_rate_clock_out(hclk),
    .bulk_data_bus_in(din), .bulk_data_bus_out(dout),
    .bulk_data_bus_oe(oe), .bulk_format_bus_in(fin),
    .bulk_format_bus_out(fout), .bulk_format_bus_oe(foe),
    .bulk_out_bus(obus), .bulk_out_format(ofmt),
    .bulk_transfer_enable(en), .bulk_rw_select(sel),
    .bulk_in_full_flag(full), .bulk_out_available_flag(avail),
    .bulk_write_dropped(drop), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_format(rx_format),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_format(tx_format));
  bdp_host_model u_host (.core_clk(core_clk), .in_clk(ic),
    .out_clk(oc), .en(en), .sel(sel), .d_wire(din), .f_wire(fin),
    .dut_d(dout), .dut_f(fout), .dut_oe(oe), .fmt_oe(foe));
  // Compares one value and counts it.
  task check(input [10:0] seen, input [10:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0t saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Prints the verdict and ends the run.
  task tally_and_finish;
    begin
      if (err_count == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Pushes one word from the link into the read FIFO.
  task push(input [2:0] f, input [7:0] d);
    begin
      @(posedge core_clk);
      #2 {rx_valid, rx_format, rx_data} = {1'b1, f, d};
      @(posedge core_clk);
      #2 rx_valid = 1'b0;
    end
  endtask
  // Half-rate clock: two cycles high, then two low.
  task t_half_rate;
    begin
      @(posedge core_clk);
      #2 rd = {10'h0, hclk};
      repeat (2) @(posedge core_clk);
      #2 check({10'h0, hclk}, ~rd & 11'h1);
      repeat (2) @(posedge core_clk);
      #2 check({10'h0, hclk}, rd);
    end
  endtask
  // Bidirectional reads of two bytes, then of an empty FIFO.
  task t_bidir_read;
    begin
      push(`BDP_FMT_START, 8'hA5);
      push(`BDP_FMT_CELL, 8'h3C);
      repeat (3) @(posedge core_clk);
      check({10'h0, avail}, 11'h1);
      u_host.xfer(1'b1, 1'b1, 1'b0, 8'h00, 3'h0, rd);
      check(rd, {`BDP_FMT_START, 8'hA5});
      u_host.xfer(1'b1, 1'b1, 1'b0, 8'h00, 3'h0, rd);
      check(rd, {`BDP_FMT_CELL, 8'h3C});
      check({10'h0, avail}, 11'h0);
      u_host.xfer(1'b1, 1'b1, 1'b0, 8'h00, 3'h0, rd);
      check(rd, {`BDP_FMT_IDLE, 8'h00});
    end
  endtask
  // Fills the write FIFO past full with the link stalled, then drains.
  task t_fill;
    begin
      for (i = 0; i < 33; i = i + 1)
        u_host.xfer(1'b1, 1'b0, 1'b0, i[7:0], `BDP_FMT_CELL, rd);
      check({9'h0, full, drop}, 11'h3);
      tx_ready = 1'b1;
      for (i = 0; i < 32; i = i + 1) begin
        check({7'h0, tx_valid, tx_format}, {7'h0, 1'b1, `BDP_FMT_CELL});
        check({3'h0, tx_data}, {3'h0, i[7:0]});
        @(posedge core_clk);
        #2;
      end
      check({9'h0, tx_valid, full}, 11'h0);
      tx_ready = 1'b0;
    end
  endtask
  // Asynchronous mode: two reads on the out port, the second of an empty FIFO, then two writes.
  task t_async;
    begin
      mode_bidir = 1'b0;
      push(`BDP_FMT_CELL, 8'h5A);
      u_host.xfer(1'b0, 1'b1, 1'b1, 8'h00, 3'h0, rd);
      check({ofmt, obus}, {`BDP_FMT_CELL, 8'h5A});
      check({10'h0, oe}, 11'h0);
      u_host.xfer(1'b0, 1'b1, 1'b1, 8'h00, 3'h0, rd);
      check({ofmt, obus}, {`BDP_FMT_IDLE, 8'h5A});
      u_host.xfer(1'b1, 1'b0, 1'b0, 8'h77, 3'h4, rd);
      u_host.xfer(1'b1, 1'b0, 1'b0, 8'h11, 3'h3, rd);
      check({tx_format, tx_data}, {`BDP_FMT_START, 8'h77});
      tx_ready = 1'b1;
      @(posedge core_clk);
      #2 tx_ready = 1'b0;
      check({tx_format, tx_data}, {`BDP_FMT_CELL, 8'h11});
    end
  endtask
  // Core clock of 50 ns.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Cuts a hung run short.
  initial begin
    #1000000;
    err_count = err_count + 1;
    tally_and_finish;
  end
  // Main sequence.
  initial begin
    {srst, mode_bidir, rx_valid, tx_ready} = 4'hC;
    {rx_data, rx_format, err_count, cmp_count} = 0;
    repeat (10) @(posedge core_clk);
    #2 srst = 1'b0;
    check({7'h0, oe, fout}, {7'h0, 1'b0, `BDP_FMT_IDLE});
    check({8'h0, full, avail, tx_valid}, 11'h0);
    repeat (4) @(posedge core_clk);
    t_half_rate;
    t_bidir_read;
    t_fill;
    t_async;
    tally_and_finish;
  end
endmodule

// >>> verilog/bdp_fifo.v
`timescale 1ns/1ns
// Flop-based FIFO with valid and ready on both sides.
module bdp_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset.
  input  wire             core_clk,
  input  wire             srst,
  // Filling side.
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side.
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg  [AW:0]      wr_ptr_r;
  reg  [AW:0]      rd_ptr_r;
  wire             full;
  wire             empty;
  wire             do_push;
  wire             do_pop;

  // Full when the pointers differ only in the wrap bit.
  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                     (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];
  assign do_push   = in_valid && !full;
  assign do_pop    = out_ready && !empty;

  // Storage is written only on an accepted push.
  always @(posedge core_clk) begin
    if (do_push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointer update.
  always @(posedge core_clk) begin
    if (srst) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule

// >>> verilog/bdp_map.vh
`ifndef BDP_MAP_VH
`define BDP_MAP_VH

// Widths of the host-side buses and of a FIFO word.
`define BDP_DATA_W      8
`define BDP_FMT_W       3
`define BDP_WORD_W      11

// Depth of each byte FIFO and its address width.
`define BDP_FIFO_DEPTH  32
`define BDP_FIFO_AW     5

// Format codes carried on the format bus.
`define BDP_FMT_START   3'h5
`define BDP_FMT_CELL    3'h1
`define BDP_FMT_IDLE    3'h4

// Field positions of a FIFO word: format above data.
`define BDP_WORD_FMT_HI 10
`define BDP_WORD_FMT_LO 8
`define BDP_WORD_DAT_HI 7
`define BDP_WORD_DAT_LO 0

// Bit of the format bus that marks the start of a cell in async mode.
`define BDP_FMT_START_BIT 2

// Half-rate clock divider: core clock cycles per half period.
`define BDP_HALF_DIV    4'h2
`define BDP_DIV_W       4

`endif

// >>> verilog/bdp_port.v
`timescale 1ns/1ns
`include "bdp_map.vh"

module bdp_port (
  // Clock and reset.
  input  wire       core_clk,
  input  wire       srst,
  // Mode strap: high selects the bidirectional mode.
  input  wire       mode_bidir,
  // Port clocks from the host side, and the divided clock offered back to it.
  input  wire       bulk_in_port_clock,
  input  wire       bulk_out_port_clock,
  output wire       half_rate_clock_out,
  // Shared data bus, split into input, output and enable.
  input  wire [7:0] bulk_data_bus_in,
  output wire [7:0] bulk_data_bus_out,
  output wire       bulk_data_bus_oe,
  // Format bus, split into input, output and enable.
  input  wire [2:0] bulk_format_bus_in,
  output wire [2:0] bulk_format_bus_out,
  output wire       bulk_format_bus_oe,
  // Async-mode read port.
  output wire [7:0] bulk_out_bus,
  output wire [2:0] bulk_out_format,
  // Transfer control from the host.
  input  wire       bulk_transfer_enable,
  input  wire       bulk_rw_select,
  // Status flags to the host.
  output wire       bulk_in_full_flag,
  output wire       bulk_out_available_flag,
  output wire       bulk_write_dropped,
  // Link side: bytes arriving for the host to read.
  input  wire       rx_valid,
  output wire       rx_ready,
  input  wire [7:0] rx_data,
  input  wire [2:0] rx_format,
  // Link side: bytes written by the host.
  output wire       tx_valid,
  input  wire       tx_ready,
  output wire [7:0] tx_data,
  output wire [2:0] tx_format
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  localparam SYNC_W = 16;

  wire [SYNC_W-1:0] sync_in;
  reg  [SYNC_W-1:0] sync1_r;
  reg  [SYNC_W-1:0] sync2_r;

  // All pins from the host are sampled through two flops.
  assign sync_in = {mode_bidir, bulk_in_port_clock, bulk_out_port_clock,
                    bulk_data_bus_in, bulk_format_bus_in,
                    bulk_transfer_enable, bulk_rw_select};

  // Both stages reset to zero; the bus sees no edge until released.
  always @(posedge core_clk) begin
    if (srst) begin
      sync1_r <= {SYNC_W{1'b0}};
      sync2_r <= {SYNC_W{1'b0}};
    end else begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
    end
  end

  wire       bidir_s;
  wire       in_clk_s;
  wire       out_clk_s;
  wire [7:0] data_s;
  wire [2:0] fmt_s;
  wire       en_s;
  wire       sel_s;

  assign bidir_s   = sync2_r[15];
  assign in_clk_s  = sync2_r[14];
  assign out_clk_s = sync2_r[13];
  assign data_s    = sync2_r[12:5];
  assign fmt_s     = sync2_r[4:2];
  assign en_s      = sync2_r[1];
  assign sel_s     = sync2_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Port clock edge detection.

  reg in_clk_d_r;
  reg out_clk_d_r;

  // Previous synchronised levels of the two port clocks.
  always @(posedge core_clk) begin
    if (srst) begin
      in_clk_d_r  <= 1'b0;
      out_clk_d_r <= 1'b0;
    end else begin
      in_clk_d_r  <= in_clk_s;
      out_clk_d_r <= out_clk_s;
    end
  end

  wire in_rise;
  wire out_rise;
  wire rd_rise;

  // Bidir mode runs both directions on the input port clock.
  assign in_rise  = in_clk_s && !in_clk_d_r;
  assign out_rise = out_clk_s && !out_clk_d_r;
  assign rd_rise  = bidir_s ? in_rise : out_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Half-rate clock output.

  reg [`BDP_DIV_W-1:0] div_cnt_r;
  reg                  half_clk_r;

  // Divides the core clock to offer the host a port clock.
  always @(posedge core_clk) begin
    if (srst) begin
      div_cnt_r  <= {`BDP_DIV_W{1'b0}};
      half_clk_r <= 1'b0;
    end else if (div_cnt_r == `BDP_HALF_DIV - 1'b1) begin
      div_cnt_r  <= {`BDP_DIV_W{1'b0}};
      half_clk_r <= !half_clk_r;
    end else begin
      div_cnt_r  <= div_cnt_r + 1'b1;
    end
  end

  assign half_rate_clock_out = half_clk_r;

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs.

  wire                   wfifo_ready;
  wire                   wfifo_push;
  wire [`BDP_WORD_W-1:0] wfifo_word;
  wire                   rfifo_valid;
  wire                   rfifo_pop;
  wire [`BDP_WORD_W-1:0] rfifo_word;

  // Host writes travel to the link through this FIFO.
  bdp_fifo #(
    .WIDTH (`BDP_WORD_W),
    .DEPTH (`BDP_FIFO_DEPTH),
    .AW    (`BDP_FIFO_AW)
  ) u_wfifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (wfifo_push),
    .in_ready  (wfifo_ready),
    .in_data   (wfifo_word),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  ({tx_format, tx_data})
  );

  // Link bytes wait here until the host reads them.
  bdp_fifo #(
    .WIDTH (`BDP_WORD_W),
    .DEPTH (`BDP_FIFO_DEPTH),
    .AW    (`BDP_FIFO_AW)
  ) u_rfifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   ({rx_format, rx_data}),
    .out_valid (rfifo_valid),
    .out_ready (rfifo_pop),
    .out_data  (rfifo_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request decode at the port clock edge.

  reg en_q_r;
  reg sel_q_r;

  // Levels of enable and select seen at the previous port edge.
  always @(posedge core_clk) begin
    if (srst) begin
      en_q_r  <= 1'b0;
      sel_q_r <= 1'b0;
    end else begin
      if (in_rise) begin
        en_q_r <= en_s;
      end
      if (rd_rise) begin
        sel_q_r <= sel_s;
      end
    end
  end

  wire       wr_req;
  wire       rd_req;
  wire [2:0] wr_fmt;

  // Async mode takes one byte per inactive-to-active request;
  // bidir mode takes a byte on every edge while enabled with select low.
  assign wr_req = in_rise && en_s && (bidir_s ? !sel_s : !en_q_r);
  assign rd_req = rd_rise && (bidir_s ? (en_s && sel_s)
                                      : (sel_s && !sel_q_r));

  // Async mode carries DV only: one bit tells start from cell.
  assign wr_fmt = bidir_s ? fmt_s :
                  (fmt_s[`BDP_FMT_START_BIT] ? `BDP_FMT_START
                                             : `BDP_FMT_CELL);

  // Writes are refused while the write FIFO is full.
  assign wfifo_push = wr_req && wfifo_ready;
  assign wfifo_word = {wr_fmt, data_s};
  assign rfifo_pop  = rd_req && rfifo_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Read data registers.

  reg [7:0] bus_data_r;
  reg [2:0] bus_fmt_r;
  reg       bus_oe_r;
  reg [7:0] out_data_r;
  reg [2:0] out_fmt_r;

  // Bidir reads load the shared bus; an empty FIFO shows idle.
  always @(posedge core_clk) begin
    if (srst) begin
      bus_data_r <= 8'h00;
      bus_fmt_r  <= `BDP_FMT_IDLE;
    end else if (rd_req && bidir_s) begin
      if (rfifo_valid) begin
        bus_data_r <= rfifo_word[`BDP_WORD_DAT_HI:`BDP_WORD_DAT_LO];
        bus_fmt_r  <= rfifo_word[`BDP_WORD_FMT_HI:`BDP_WORD_FMT_LO];
      end else begin
        bus_data_r <= 8'h00;
        bus_fmt_r  <= `BDP_FMT_IDLE;
      end
    end
  end

  // The shared bus is driven only while a read is enabled.
  always @(posedge core_clk) begin
    if (srst) begin
      bus_oe_r <= 1'b0;
    end else begin
      bus_oe_r <= bidir_s && en_s && sel_s;
    end
  end

  // Async reads update the read port well before the next edge.
  always @(posedge core_clk) begin
    if (srst) begin
      out_data_r <= 8'h00;
      out_fmt_r  <= `BDP_FMT_IDLE;
    end else if (rd_req && !bidir_s) begin
      if (rfifo_valid) begin
        out_data_r <= rfifo_word[`BDP_WORD_DAT_HI:`BDP_WORD_DAT_LO];
        out_fmt_r  <= rfifo_word[`BDP_WORD_FMT_HI:`BDP_WORD_FMT_LO];
      end else begin
        out_fmt_r  <= `BDP_FMT_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.

  reg full_r;
  reg avail_r;
  reg drop_r;

  // Flags follow the FIFO levels; a dropped write is remembered.
  always @(posedge core_clk) begin
    if (srst) begin
      full_r  <= 1'b0;
      avail_r <= 1'b0;
      drop_r  <= 1'b0;
    end else begin
      full_r  <= !wfifo_ready;
      avail_r <= rfifo_valid;
      if (wr_req && !wfifo_ready) begin
        drop_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign bulk_data_bus_out       = bus_data_r;
  assign bulk_data_bus_oe        = bus_oe_r;
  assign bulk_format_bus_out     = bus_fmt_r;
  assign bulk_format_bus_oe      = bus_oe_r;
  assign bulk_out_bus            = out_data_r;
  assign bulk_out_format         = out_fmt_r;
  assign bulk_in_full_flag       = full_r;
  assign bulk_out_available_flag = avail_r;
  assign bulk_write_dropped      = drop_r;

endmodule
